// ### bench/tb_top.sv
// Testbench for the dual-clock up/down counter
`timescale 1ns/100ps
`include "udc_defines.vh"

module tb_top;
  localparam IDLE = 4'hd;
  localparam UPLO = 4'h5;
  localparam DNLO = 4'h9;
  localparam LOAD = 4'hc;
  localparam CLR = 4'hf;
  localparam CLRLD = 4'he;
  localparam BOTHLO = 4'h1;
  reg mclk;
  reg arst_n;
  reg [2:0] reg_addr;
  reg [7:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  wire up_clock, down_clock, clear_in, preset_load_n;
  wire [3:0] preset, dq, bq, hq;
  wire d_cy, d_bw, b_cy, b_bw;
  wire [7:0] d_rdata, b_rdata;
  integer fail_count;
  integer checks_done;
  integer i;
  reg [3:0] ed, eb;

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  udc_ctrl_model ctl (.mclk(mclk), .up_clock(up_clock), .down_clock(down_clock), .clear_in(clear_in),
    .preset_load_n(preset_load_n), .preset(preset));

  udc_counter #(.DECIMAL(1)) uut (.mclk(mclk), .arst_n(arst_n), .up_clock(up_clock), .down_clock(down_clock),
    .clear_in(clear_in), .preset_load_n(preset_load_n), .preset_bit0(preset[0]), .preset_bit1(preset[1]),
    .preset_bit2(preset[2]), .preset_bit3(preset[3]), .count_bit0(dq[0]), .count_bit1(dq[1]), .count_bit2(dq[2]),
    .count_bit3(dq[3]), .carry_out_n(d_cy), .borrow_out_n(d_bw), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(d_rdata));

  udc_counter #(.DECIMAL(0)) uut_bin (.mclk(mclk), .arst_n(arst_n), .up_clock(up_clock), .down_clock(down_clock),
    .clear_in(clear_in), .preset_load_n(preset_load_n), .preset_bit0(preset[0]), .preset_bit1(preset[1]),
    .preset_bit2(preset[2]), .preset_bit3(preset[3]), .count_bit0(bq[0]), .count_bit1(bq[1]), .count_bit2(bq[2]),
    .count_bit3(bq[3]), .carry_out_n(b_cy), .borrow_out_n(b_bw), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(b_rdata));

  // Next decade stage clocked by the terminal counts of uut
  udc_counter #(.DECIMAL(1)) uut_hi (.mclk(mclk), .arst_n(arst_n), .up_clock(d_cy), .down_clock(d_bw),
    .clear_in(clear_in), .preset_load_n(preset_load_n), .preset_bit0(preset[0]), .preset_bit1(preset[1]),
    .preset_bit2(preset[2]), .preset_bit3(preset[3]), .count_bit0(hq[0]), .count_bit1(hq[1]), .count_bit2(hq[2]),
    .count_bit3(hq[3]), .carry_out_n(), .borrow_out_n(), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata());

  task check(input [8*16-1:0] name, input [7:0] exp, input [7:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task go(input [3:0] pins, input [3:0] p, input [3:0] xd, input [3:0] xb);
    begin
      ctl.drive(pins, p);
      check("decade count", {4'h0, xd}, {4'h0, dq});
      check("binary count", {4'h0, xb}, {4'h0, bq});
    end
  endtask

  task flags(input [3:0] x);
    begin
      check("terminal outs", {4'h0, x}, {4'h0, d_cy, d_bw, b_cy, b_bw});
    end
  endtask

  task reg_read(input [2:0] a, input [7:0] exp);
    begin
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      check("register", exp, d_rdata);
      check("register bin", exp, b_rdata);
    end
  endtask

  task reg_write(input [2:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count = fail_count + 1;
    print_verdict;
  end

  initial begin
    fail_count = 0;
    checks_done = 0;
    arst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    go(IDLE, 4'h0, 4'h0, 4'h0);
    flags(4'hf);
    reg_read(`UDC_REG_STATUS, 8'h30);
    reg_write(3'h6, 8'hff);
    reg_read(3'h6, 8'h00);
    go(LOAD, 4'h7, 4'h7, 4'h7);
    go(LOAD, 4'h3, 4'h3, 4'h3);
    go(IDLE, 4'h3, 4'h3, 4'h3);
    go(IDLE, 4'h5, 4'h3, 4'h3);
    go(CLR, 4'h5, 4'h0, 4'h0);
    go(IDLE, 4'h5, 4'h0, 4'h0);
    ed = 4'h0;
    eb = 4'h0;
    for (i = 0; i < 16; i = i + 1) begin
      go(UPLO, 4'h5, ed, eb);
      flags({ed != 4'h9, 1'b1, eb != 4'hf, 1'b1});
      ed = (ed == 4'h9) ? 4'h0 : ed + 4'h1;
      eb = eb + 4'h1;
      go(IDLE, 4'h5, ed, eb);
    end
    check("cascade count", 8'h01, {4'h0, hq});
    for (i = 0; i < 16; i = i + 1) begin
      go(DNLO, 4'h5, ed, eb);
      flags({1'b1, ed != 4'h0, 1'b1, eb != 4'h0});
      ed = (ed == 4'h0) ? 4'h9 : ed - 4'h1;
      eb = eb - 4'h1;
      go(IDLE, 4'h5, ed, eb);
    end
    check("cascade count", 8'h00, {4'h0, hq});
    go(CLRLD, 4'ha, 4'h0, 4'h0);
    go(CLR, 4'ha, 4'h0, 4'h0);
    go(IDLE, 4'ha, 4'h0, 4'h0);
    go(LOAD, 4'hc, 4'hc, 4'hc);
    go(IDLE, 4'hc, 4'hc, 4'hc);
    go(UPLO, 4'hc, 4'hc, 4'hc);
    go(IDLE, 4'hc, 4'h0, 4'hd);
    go(LOAD, 4'hf, 4'hf, 4'hf);
    go(IDLE, 4'hf, 4'hf, 4'hf);
    go(DNLO, 4'hf, 4'hf, 4'hf);
    go(IDLE, 4'hf, 4'he, 4'he);
    go(BOTHLO, 4'hf, 4'he, 4'he);
    go(IDLE, 4'hf, 4'he, 4'he);
    reg_read(`UDC_REG_FAULT, 8'h01);
    reg_write(`UDC_REG_FAULT, 8'h01);
    reg_read(`UDC_REG_FAULT, 8'h00);
    reg_read(`UDC_REG_UP_TALLY, 8'h11);
    reg_read(`UDC_REG_DOWN_TALLY, 8'h11);
    reg_write(`UDC_REG_UP_TALLY, 8'h00);
    reg_read(`UDC_REG_UP_TALLY, 8'h00);
    print_verdict;
  end
endmodule // tb_top

bind udc_counter udc_counter_asserts #(.DECIMAL(DECIMAL)) chk (.mclk(mclk), .arst_n(arst_n), .up_clock(up_clock),
  .down_clock(down_clock), .clear_in(clear_in), .preset_load_n(preset_load_n), .preset_bit0(preset_bit0),
  .preset_bit1(preset_bit1), .preset_bit2(preset_bit2), .preset_bit3(preset_bit3), .count_bit0(count_bit0),
  .count_bit1(count_bit1), .count_bit2(count_bit2), .count_bit3(count_bit3), .carry_out_n(carry_out_n),
  .borrow_out_n(borrow_out_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ### bench/udc_counter_asserts.sv
// Checker for the dual-clock up/down counter
`timescale 1ns/100ps
`include "udc_defines.vh"

module udc_counter_asserts #(
  parameter DECIMAL = 1
) (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Pins
  input wire up_clock,
  input wire down_clock,
  input wire clear_in,
  input wire preset_load_n,
  input wire preset_bit0,
  input wire preset_bit1,
  input wire preset_bit2,
  input wire preset_bit3,
  // Outputs
  input wire count_bit0,
  input wire count_bit1,
  input wire count_bit2,
  input wire count_bit3,
  input wire carry_out_n,
  input wire borrow_out_n,
  // Register port
  input wire [`UDC_ADDR_WIDTH-1:0] reg_addr,
  input wire reg_rd,
  input wire [`UDC_DATA_WIDTH-1:0] reg_rdata
);
  wire [3:0] q = {count_bit3, count_bit2, count_bit1, count_bit0};
  wire [3:0] p = {preset_bit3, preset_bit2, preset_bit1, preset_bit0};
  wire [3:0] top = DECIMAL ? 4'h9 : 4'hf;
  reg [2:0] live;

  // Pins take three samples to reach the outputs
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      live <= 3'h0;
    end else if (live != 3'h7) begin
      live <= live + 3'h1;
    end
  end

  function [3:0] up1(input [3:0] c);
    up1 = (DECIMAL != 0 && c >= 4'h9) ? 4'h0 : c + 4'h1;
  endfunction

  function [3:0] dn1(input [3:0] c);
    dn1 = (DECIMAL != 0 && c == 4'h0) ? 4'h9 : c - 4'h1;
  endfunction

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_clear;
    live == 3'h7 && $past(clear_in, 3) |-> q == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");

  property p_clear_wins;
    live == 3'h7 && $past(clear_in, 3) && !$past(preset_load_n, 3) |-> q == 4'h0 && borrow_out_n == $past(down_clock, 3);
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("load beat clear");

  property p_load;
    live == 3'h7 && !$past(clear_in, 3) && !$past(preset_load_n, 3) |-> q == $past(p, 3);
  endproperty
  a_load: assert property (p_load) else $error("preset not copied");

  property p_hold;
    live == 3'h7 && $past(preset_load_n, 3) && !$past(clear_in, 3) && !($past(up_clock, 3) && !$past(up_clock, 4))
      && !($past(down_clock, 3) && !$past(down_clock, 4)) |-> q == $past(q);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without edge");

  property p_up;
    live == 3'h7 && $past(up_clock, 3) && !$past(up_clock, 4) && $past(down_clock, 3) && $past(down_clock, 4)
      && $past(preset_load_n, 4) && $past(preset_load_n, 3) && !$past(clear_in, 4) && !$past(clear_in, 3) |-> q == up1($past(q));
  endproperty
  a_up: assert property (p_up) else $error("bad up step");

  property p_down;
    live == 3'h7 && $past(down_clock, 3) && !$past(down_clock, 4) && $past(up_clock, 3) && $past(up_clock, 4)
      && $past(preset_load_n, 4) && $past(preset_load_n, 3) && !$past(clear_in, 4) && !$past(clear_in, 3) |-> q == dn1($past(q));
  endproperty
  a_down: assert property (p_down) else $error("bad down step");

  property p_carry;
    live == 3'h7 |-> carry_out_n == !(!$past(up_clock, 3) && q == top);
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");

  property p_borrow;
    live == 3'h7 |-> borrow_out_n == !(!$past(down_clock, 3) && q == 4'h0);
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow wrong");

  property p_status;
    $past(reg_rd) && $past(reg_addr) == 3'h0 |-> reg_rdata[5:0] == {$past(borrow_out_n), $past(carry_out_n), $past(q)};
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
endmodule // udc_counter_asserts

// ### bench/udc_ctrl_model.sv
// Surrounding control logic that drives the counter pins
`timescale 1ns/100ps

module udc_ctrl_model (
  // Clock
  input wire mclk,
  // Counter pins
  output reg up_clock,
  output reg down_clock,
  output reg clear_in,
  output reg preset_load_n,
  output reg [3:0] preset
);
  // Idle: both count clocks high, no clear, no load
  initial begin
    up_clock = 1'b1;
    down_clock = 1'b1;
    clear_in = 1'b0;
    preset_load_n = 1'b1;
    preset = 4'h0;
  end

  // Pins are {up, down, clear, load_n}; hold long enough to be seen
  task drive(input [3:0] pins, input [3:0] p);
    begin
      @(posedge mclk);
      up_clock <= pins[3];
      down_clock <= pins[2];
      clear_in <= pins[1];
      preset_load_n <= pins[0];
      preset <= p;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
    end
  endtask
endmodule // udc_ctrl_model

// ### core/udc_counter.v
// Dual-clock up/down counter with preset, clear, terminal counts and status port
//
// Overview of operation
// - A high clear input forces the count to zero regardless of every other input and of the count clocks.
// - With clear and preset-load both active the clear wins and the count ends at zero.
// - While preset-load is low and clear is low the preset data are copied onto the count outputs.
// - When preset-load rises the last loaded value is kept and later count clocks step on from it.
// - While preset-load is high the preset data inputs have no effect on the count.
// - Apart from clear and preset-load, the count changes only after a rising edge on the up clock or on the down clock.
// - An up clock pulse with the down clock high counts up, a down clock pulse with the up clock high counts down.
// - The decade variant runs zero to nine, wrapping nine to zero upward and zero to nine downward.
// - The binary variant runs all sixteen codes with wraps at fifteen and zero, loading and clearing alike.
// - The carry output is low only while the up clock is low and the count is at its maximum.
// - The borrow output is low only while the down clock is low and the count is zero.
`timescale 1ns/100ps
`include "udc_defines.vh"

module udc_counter #(
  parameter DECIMAL = 1
) (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Count clocks
  input wire up_clock,
  input wire down_clock,
  // Clear and preset
  input wire clear_in,
  input wire preset_load_n,
  input wire preset_bit0,
  input wire preset_bit1,
  input wire preset_bit2,
  input wire preset_bit3,
  // Count outputs
  output wire count_bit0,
  output wire count_bit1,
  output wire count_bit2,
  output wire count_bit3,
  // Terminal counts
  output reg carry_out_n,
  output reg borrow_out_n,
  // Register port
  input wire [`UDC_ADDR_WIDTH-1:0] reg_addr,
  input wire [`UDC_DATA_WIDTH-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`UDC_DATA_WIDTH-1:0] reg_rdata
);

  localparam [3:0] MAX_COUNT = (DECIMAL != 0) ? `UDC_DEC_MAX : `UDC_BIN_MAX;

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  wire [`UDC_PIN_WIDTH-1:0] pin_raw;
  wire [`UDC_PIN_WIDTH-1:0] pin_s;

  assign pin_raw = {preset_bit3, preset_bit2, preset_bit1, preset_bit0,
                    preset_load_n, clear_in, down_clock, up_clock};

  udc_sync #(
    .WIDTH(`UDC_PIN_WIDTH),
    .RST_VAL(`UDC_PIN_RESET)
  ) u_pin_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin_in(pin_raw),
    .pin_sync(pin_s)
  );

  wire up_s;
  wire down_s;
  wire clear_s;
  wire load_n_s;
  wire [3:0] preset_s;

  assign up_s = pin_s[`UDC_PIN_UP];
  assign down_s = pin_s[`UDC_PIN_DOWN];
  assign clear_s = pin_s[`UDC_PIN_CLEAR];
  assign load_n_s = pin_s[`UDC_PIN_LOAD_N];
  assign preset_s = pin_s[`UDC_PIN_PRE_MSB:`UDC_PIN_PRE_LSB];

  // --------------------------------------------------------------------------
  // Edge detection on synchronised levels
  // --------------------------------------------------------------------------
  reg up_d;
  reg down_d;
  reg clear_d;
  reg load_n_d;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      up_d <= 1'b1;
      down_d <= 1'b1;
      clear_d <= 1'b0;
      load_n_d <= 1'b1;
    end else begin
      up_d <= up_s;
      down_d <= down_s;
      clear_d <= clear_s;
      load_n_d <= load_n_s;
    end
  end

  wire up_rise;
  wire down_rise;
  wire step_up;
  wire step_down;
  wire both_low;
  wire release_race;

  assign up_rise = up_s & ~up_d;
  assign down_rise = down_s & ~down_d;
  // Direction set by which clock pulses while the other stays high
  assign step_up = up_rise & down_s & ~down_rise;
  assign step_down = down_rise & up_s & ~up_rise;
  // Both clocks low is illegal drive; counting holds and a fault is logged
  assign both_low = ~up_s & ~down_s;
  // Clear and preset-load released in the same sample
  assign release_race = clear_d & ~clear_s & ~load_n_d & load_n_s;

  // --------------------------------------------------------------------------
  // Count state
  // --------------------------------------------------------------------------
  reg [3:0] count;
  reg [3:0] next_count;
  wire [3:0] count_inc;
  wire [3:0] count_dec;

  udc_step #(
    .DECIMAL(DECIMAL),
    .COUNT_UP(1)
  ) u_step_up (
    .cur(count),
    .nxt(count_inc)
  );

  udc_step #(
    .DECIMAL(DECIMAL),
    .COUNT_UP(0)
  ) u_step_down (
    .cur(count),
    .nxt(count_dec)
  );

  always @* begin
    next_count = count;
    if (clear_s) begin
      next_count = `UDC_ZERO;
    end else if (!load_n_s) begin
      next_count = preset_s;
    end else if (step_up && !both_low) begin
      // Preset data ignored here; stepping from the held load value
      next_count = count_inc;
    end else if (step_down && !both_low) begin
      next_count = count_dec;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= `UDC_ZERO;
    end else begin
      count <= next_count;
    end
  end

  assign count_bit0 = count[0];
  assign count_bit1 = count[1];
  assign count_bit2 = count[2];
  assign count_bit3 = count[3];

  // --------------------------------------------------------------------------
  // Terminal counts, aligned with the count register
  // --------------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      carry_out_n <= 1'b1;
      borrow_out_n <= 1'b1;
    end else begin
      carry_out_n <= ~(~up_s & (next_count == MAX_COUNT));
      borrow_out_n <= ~(~down_s & (next_count == `UDC_ZERO));
    end
  end

  // --------------------------------------------------------------------------
  // Fault flags and step tallies
  // --------------------------------------------------------------------------
  reg flt_both_low;
  reg flt_race;
  reg [7:0] up_tally;
  reg [7:0] down_tally;
  wire wr_fault;
  wire wr_up_tally;
  wire wr_down_tally;
  wire counted_up;
  wire counted_down;

  assign wr_fault = reg_wr & (reg_addr == `UDC_REG_FAULT);
  assign wr_up_tally = reg_wr & (reg_addr == `UDC_REG_UP_TALLY);
  assign wr_down_tally = reg_wr & (reg_addr == `UDC_REG_DOWN_TALLY);
  assign counted_up = ~clear_s & load_n_s & step_up & ~both_low;
  assign counted_down = ~clear_s & load_n_s & step_down & ~both_low;

  // New events win over a clearing write in the same cycle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flt_both_low <= 1'b0;
      flt_race <= 1'b0;
    end else begin
      if (both_low) begin
        flt_both_low <= 1'b1;
      end else if (wr_fault && reg_wdata[`UDC_FLT_BOTH_LOW]) begin
        flt_both_low <= 1'b0;
      end
      if (release_race) begin
        flt_race <= 1'b1;
      end else if (wr_fault && reg_wdata[`UDC_FLT_RACE]) begin
        flt_race <= 1'b0;
      end
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      up_tally <= 8'h00;
      down_tally <= 8'h00;
    end else begin
      if (counted_up) begin
        up_tally <= up_tally + 8'h01;
      end else if (wr_up_tally) begin
        up_tally <= 8'h00;
      end
      if (counted_down) begin
        down_tally <= down_tally + 8'h01;
      end else if (wr_down_tally) begin
        down_tally <= 8'h00;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register read path
  // --------------------------------------------------------------------------
  reg [`UDC_DATA_WIDTH-1:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `UDC_REG_STATUS: begin
          next_rdata[`UDC_ST_COUNT_MSB:`UDC_ST_COUNT_LSB] = count;
          next_rdata[`UDC_ST_CARRY_N] = carry_out_n;
          next_rdata[`UDC_ST_BORROW_N] = borrow_out_n;
          next_rdata[`UDC_ST_LOADING] = ~load_n_s;
          next_rdata[`UDC_ST_CLEARING] = clear_s;
        end
        `UDC_REG_FAULT: begin
          next_rdata[`UDC_FLT_BOTH_LOW] = flt_both_low;
          next_rdata[`UDC_FLT_RACE] = flt_race;
        end
        `UDC_REG_PRESET: begin
          next_rdata[3:0] = preset_s;
        end
        `UDC_REG_UP_TALLY: begin
          next_rdata = up_tally;
        end
        `UDC_REG_DOWN_TALLY: begin
          next_rdata = down_tally;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Read data stand for one cycle only
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // udc_counter

// ### core/udc_step.v
// Successor or predecessor of a 4-bit count, decade or binary
`timescale 1ns/100ps
`include "udc_defines.vh"

module udc_step #(
  parameter DECIMAL = 1,
  parameter COUNT_UP = 1
) (
  // Current state
  input wire [3:0] cur,
  // Next state in the chosen direction
  output reg [3:0] nxt
);

  always @* begin
    nxt = cur;
    if (COUNT_UP != 0) begin
      // Decade codes at or above nine fall back to zero
      if (DECIMAL != 0 && cur >= `UDC_DEC_MAX) begin
        nxt = `UDC_ZERO;
      end else begin
        nxt = cur + 4'h1;
      end
    end else begin
      if (cur == `UDC_ZERO) begin
        nxt = (DECIMAL != 0) ? `UDC_DEC_MAX : `UDC_BIN_MAX;
      end else begin
        // Invalid decade codes walk down into nine
        nxt = cur - 4'h1;
      end
    end
  end

endmodule // udc_step

// ### core/udc_sync.v
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps

module udc_sync #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Pin side
  input wire [WIDTH-1:0] pin_in,
  // Synchronised side
  output reg [WIDTH-1:0] pin_sync
);

  reg [WIDTH-1:0] stage1;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= RST_VAL;
      pin_sync <= RST_VAL;
    end else begin
      stage1 <= pin_in;
      pin_sync <= stage1;
    end
  end

endmodule // udc_sync

// ### include/udc_defines.vh
// Constants for the dual-clock up/down counter
`ifndef UDC_DEFINES_VH
`define UDC_DEFINES_VH

// ----------------------------------------------------------------------------
// Count limits
// ----------------------------------------------------------------------------
`define UDC_ZERO 4'h0
`define UDC_DEC_MAX 4'h9
`define UDC_BIN_MAX 4'hf

// ----------------------------------------------------------------------------
// Pin synchroniser layout and reset values
// ----------------------------------------------------------------------------
`define UDC_PIN_WIDTH 8
`define UDC_PIN_UP 0
`define UDC_PIN_DOWN 1
`define UDC_PIN_CLEAR 2
`define UDC_PIN_LOAD_N 3
`define UDC_PIN_PRE_LSB 4
`define UDC_PIN_PRE_MSB 7
`define UDC_PIN_RESET 8'h0b

// ----------------------------------------------------------------------------
// Register port
// ----------------------------------------------------------------------------
`define UDC_ADDR_WIDTH 3
`define UDC_DATA_WIDTH 8
`define UDC_REG_STATUS 3'h0
`define UDC_REG_FAULT 3'h1
`define UDC_REG_PRESET 3'h2
`define UDC_REG_UP_TALLY 3'h3
`define UDC_REG_DOWN_TALLY 3'h4

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define UDC_ST_COUNT_LSB 0
`define UDC_ST_COUNT_MSB 3
`define UDC_ST_CARRY_N 4
`define UDC_ST_BORROW_N 5
`define UDC_ST_LOADING 6
`define UDC_ST_CLEARING 7

// ----------------------------------------------------------------------------
// Fault register fields (write one to clear)
// ----------------------------------------------------------------------------
`define UDC_FLT_BOTH_LOW 0
`define UDC_FLT_RACE 1

`endif
